// File: rtl/dpcd_cnt_if.sv
// control and result signals between the top and one counter
`timescale 1ns/1ps
`default_nettype none
interface dpcd_cnt_if #(parameter int WIDTH = 32);
    logic gate;
    logic clear;
    logic latch;
    logic inc;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] snapshot;
    modport ctrl (output gate, output clear, output latch, output inc, input count, input snapshot);
    modport cnt (input gate, input clear, input latch, input inc, output count, output snapshot);
endinterface
`default_nettype wire

// File: rtl/dpcd_counter.sv
// one 32-bit pulse counter with its snapshot register
`timescale 1ns/1ps
`default_nettype none
module dpcd_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control from the top
    dpcd_cnt_if.cnt bus
);
    if (WIDTH < 2) begin : g_chk
        $error("dpcd_counter: WIDTH must be at least 2");
    end

    // clear wins over a coincident edge; wraps silently past all ones
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.count <= '0;
        end else if (bus.clear) begin
            bus.count <= '0;
        end else if (bus.gate && bus.inc) begin
            bus.count <= bus.count + WIDTH'(1);
        end
    end

    // snapshot takes the count as it stood before any same-cycle clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.snapshot <= '0;
        end else if (bus.latch) begin
            bus.snapshot <= bus.count;
        end
    end

    a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.gate && bus.inc && !bus.clear |=> bus.count == WIDTH'($past(bus.count) + WIDTH'(1)))
        else $error("counter did not step by one on an enabled edge");
    a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !bus.gate && !bus.clear |=> $stable(bus.count))
        else $error("stopped counter changed");
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.clear |=> bus.count == '0)
        else $error("clear did not zero the counter");
    a_snap_take: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bus.latch |=> bus.snapshot == $past(bus.count))
        else $error("snapshot did not take the live count");
    a_snap_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !bus.latch |=> $stable(bus.snapshot))
        else $error("snapshot changed without a command");
endmodule // dpcd_counter
`default_nettype wire

// File: rtl/dpcd_params.svh
// register offsets, field positions, widths and reset values of the pulse counter and digital port
`ifndef DPCD_PARAMS_SVH
`define DPCD_PARAMS_SVH

`define DPCD_ADDR_W 12
`define DPCD_DATA_W 32
`define DPCD_CNT_W 32
`define DPCD_NUM_CNT 2
`define DPCD_DIO_W 6

`define DPCD_OFS_SNAP1 12'h204
`define DPCD_OFS_SNAP2 12'h214
`define DPCD_OFS_FETCH1 12'h224
`define DPCD_OFS_FETCH2 12'h234
`define DPCD_OFS_GATE 12'h300
`define DPCD_OFS_CLEAR 12'h310
`define DPCD_OFS_LATCH 12'h320
`define DPCD_OFS_IN_ALL 12'h400
`define DPCD_OFS_OUT_ALL 12'h410
`define DPCD_OFS_OUT_HIGH 12'h414
`define DPCD_OFS_OUT_LOW 12'h418
`define DPCD_OFS_EVENT 12'h420
`define DPCD_OFS_IN_BIT0 12'h440
`define DPCD_OFS_IN_BIT5 12'h454

`define DPCD_CNT_IN_LSB 4
`define DPCD_TRIG_BIT 6
`define DPCD_RST_GATE 2'h0
`define DPCD_RST_OUT 6'h00
`define DPCD_IDLE_TRIG 1'b1

`endif

// File: rtl/dpcd_pkg.sv
// types shared by the pulse counter and digital port modules
package dpcd_pkg;
    typedef enum logic [3:0] {
        REG_NONE = 4'h0,
        REG_SNAP1 = 4'h1,
        REG_SNAP2 = 4'h2,
        REG_FETCH1 = 4'h3,
        REG_FETCH2 = 4'h4,
        REG_GATE = 4'h5,
        REG_CLEAR = 4'h6,
        REG_LATCH = 4'h7,
        REG_IN_ALL = 4'h8,
        REG_IN_BIT = 4'h9,
        REG_OUT_ALL = 4'ha,
        REG_OUT_HIGH = 4'hb,
        REG_OUT_LOW = 4'hc,
        REG_EVENT = 4'hd
    } dpcd_reg_type;
endpackage

// File: rtl/dpcd_sync_edge.sv
// two-stage synchroniser with rising-edge detection for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dpcd_sync_edge #(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pins and synchronised results
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // first stage is read only by the second stage; reset to idle levels so no false edge follows reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= IDLE;
            level <= IDLE;
            prev <= IDLE;
        end else begin
            meta <= asyncIn;
            level <= meta;
            prev <= level;
        end
    end

    // edge taken after synchronisation so one edge yields one pulse
    assign rise = level & ~prev;
endmodule // dpcd_sync_edge
`default_nettype wire

// File: rtl/dpcd_top.sv
// two pulse counters with snapshots, six-bit digital port and trigger event
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dpcd_params.svh"

//
// Contract
// - two independent unsigned 32-bit counters
// - count up once per input rising edge
// - snapshot copied only on command, reads use it; a fetch read also copies it and returns the live count
// - one command bit per counter
// - gate one counts, gate zero stops
// - gate write sets both counters at once
// - snapshot bit one copies, zero does nothing
// - snapshot and clear bits self-clear
// - gate setting persists until rewritten
// - plain read returns snapshot without copying
// - six digital inputs and six outputs
// - top two inputs also count, still readable
// - read one or all, write all, set/clear one
// - trigger rising edge raises immediate event
// - clear bit one zeroes live count
module dpcd_top #(
    parameter int CNT_W = `DPCD_CNT_W,
    parameter int DIO_W = `DPCD_DIO_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [`DPCD_ADDR_W-1:0] addr,
    input wire logic [`DPCD_DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [`DPCD_DATA_W-1:0] rdData,
    // digital port and trigger pins
    input wire logic [DIO_W-1:0] read_single_input,
    input wire logic trigIn,
    output logic [DIO_W-1:0] digOut,
    // event to start the event-driven process
    output logic eventStart,
    output logic eventFlag
);
    localparam int NCNT = `DPCD_NUM_CNT;

    default clocking cbTop @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    if (CNT_W < 2 || CNT_W > `DPCD_DATA_W) begin : g_chk_cnt
        $error("dpcd_top: CNT_W must lie between 2 and the data width");
    end
    if (DIO_W != `DPCD_DIO_W) begin : g_chk_dio
        $error("dpcd_top: the port layout serves exactly six lines");
    end

    // address decode, shared by the write and read paths
    function automatic dpcd_pkg::dpcd_reg_type decodeAddr(input logic [`DPCD_ADDR_W-1:0] a);
        dpcd_pkg::dpcd_reg_type r;
        r = dpcd_pkg::REG_NONE;
        unique case (a)
            `DPCD_OFS_SNAP1: r = dpcd_pkg::REG_SNAP1;
            `DPCD_OFS_SNAP2: r = dpcd_pkg::REG_SNAP2;
            `DPCD_OFS_FETCH1: r = dpcd_pkg::REG_FETCH1;
            `DPCD_OFS_FETCH2: r = dpcd_pkg::REG_FETCH2;
            `DPCD_OFS_GATE: r = dpcd_pkg::REG_GATE;
            `DPCD_OFS_CLEAR: r = dpcd_pkg::REG_CLEAR;
            `DPCD_OFS_LATCH: r = dpcd_pkg::REG_LATCH;
            `DPCD_OFS_IN_ALL: r = dpcd_pkg::REG_IN_ALL;
            `DPCD_OFS_OUT_ALL: r = dpcd_pkg::REG_OUT_ALL;
            `DPCD_OFS_OUT_HIGH: r = dpcd_pkg::REG_OUT_HIGH;
            `DPCD_OFS_OUT_LOW: r = dpcd_pkg::REG_OUT_LOW;
            `DPCD_OFS_EVENT: r = dpcd_pkg::REG_EVENT;
            default: begin
                if (a >= `DPCD_OFS_IN_BIT0 && a <= `DPCD_OFS_IN_BIT5 && a[1:0] == 2'h0) begin
                    r = dpcd_pkg::REG_IN_BIT;
                end
            end
        endcase
        return r;
    endfunction

    // bit index carried in the low bits of the set/clear data
    function automatic logic [DIO_W-1:0] bitMask(input logic [`DPCD_DATA_W-1:0] d);
        logic [DIO_W-1:0] m;
        m = '0;
        if (d[2:0] < 3'h6) begin
            m[d[2:0]] = 1'b1;
        end
        return m;
    endfunction

    // synchronised pins: six data inputs plus the trigger on top
    logic [DIO_W:0] pinLevel;
    logic [DIO_W:0] pinRise;

    dpcd_sync_edge #(
        .WIDTH(DIO_W + 1),
        .IDLE({`DPCD_IDLE_TRIG, {DIO_W{1'b0}}})
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({trigIn, read_single_input}),
        .level(pinLevel),
        .rise(pinRise)
    );

    dpcd_cnt_if #(.WIDTH(CNT_W)) cntBus [NCNT] ();

    dpcd_pkg::dpcd_reg_type wrSel;
    dpcd_pkg::dpcd_reg_type rdSel;
    logic wrGate;
    logic wrClear;
    logic wrLatch;
    logic [NCNT-1:0] gate;
    logic [NCNT-1:0] fetchReq;
    logic [CNT_W-1:0] liveCount [NCNT];
    logic [CNT_W-1:0] snapValue [NCNT];

    assign wrSel = wrStrobe ? decodeAddr(addr) : dpcd_pkg::REG_NONE;
    assign rdSel = rdStrobe ? decodeAddr(addr) : dpcd_pkg::REG_NONE;
    assign wrGate = (wrSel == dpcd_pkg::REG_GATE);
    assign wrClear = (wrSel == dpcd_pkg::REG_CLEAR);
    assign wrLatch = (wrSel == dpcd_pkg::REG_LATCH);
    assign fetchReq = {rdSel == dpcd_pkg::REG_FETCH2, rdSel == dpcd_pkg::REG_FETCH1};

    // gate flops hold their value between writes; both bits written together
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate <= `DPCD_RST_GATE;
        end else if (wrGate) begin
            gate <= wrData[NCNT-1:0];
        end
    end

    // per-counter controls: command strobes are one-cycle pulses, never stored
    for (genvar i = 0; i < NCNT; i++) begin : g_cnt
        assign cntBus[i].gate = gate[i];
        assign cntBus[i].clear = wrClear && wrData[i];
        assign cntBus[i].latch = (wrLatch && wrData[i]) || fetchReq[i];
        assign cntBus[i].inc = pinRise[`DPCD_CNT_IN_LSB + i];
        assign liveCount[i] = cntBus[i].count;
        assign snapValue[i] = cntBus[i].snapshot;

        dpcd_counter #(
            .WIDTH(CNT_W)
        ) u_cnt (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .bus(cntBus[i])
        );
    end

    // output port: word write, then single-bit set or clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            digOut <= `DPCD_RST_OUT;
        end else begin
            unique case (wrSel)
                dpcd_pkg::REG_OUT_ALL: digOut <= wrData[DIO_W-1:0];
                dpcd_pkg::REG_OUT_HIGH: digOut <= digOut | bitMask(wrData);
                dpcd_pkg::REG_OUT_LOW: digOut <= digOut & ~bitMask(wrData);
                default: digOut <= digOut;
            endcase
        end
    end

    // trigger: one-cycle start pulse plus a sticky flag; a new edge beats the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventStart <= 1'b0;
        end else begin
            eventStart <= pinRise[`DPCD_TRIG_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventFlag <= 1'b0;
        end else if (pinRise[`DPCD_TRIG_BIT]) begin
            eventFlag <= 1'b1;
        end else if (wrSel == dpcd_pkg::REG_EVENT && wrData[0]) begin
            eventFlag <= 1'b0;
        end
    end

    // read path: data stand in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            unique case (rdSel)
                dpcd_pkg::REG_SNAP1: rdData <= `DPCD_DATA_W'(snapValue[0]);
                dpcd_pkg::REG_SNAP2: rdData <= `DPCD_DATA_W'(snapValue[1]);
                // fetch returns the value being copied into the snapshot this cycle
                dpcd_pkg::REG_FETCH1: rdData <= `DPCD_DATA_W'(liveCount[0]);
                dpcd_pkg::REG_FETCH2: rdData <= `DPCD_DATA_W'(liveCount[1]);
                dpcd_pkg::REG_GATE: rdData <= `DPCD_DATA_W'(gate);
                dpcd_pkg::REG_IN_ALL: rdData <= `DPCD_DATA_W'(pinLevel[DIO_W-1:0]);
                dpcd_pkg::REG_IN_BIT: rdData <= `DPCD_DATA_W'(pinLevel[addr[4:2]]);
                dpcd_pkg::REG_OUT_ALL: rdData <= `DPCD_DATA_W'(digOut);
                dpcd_pkg::REG_EVENT: rdData <= `DPCD_DATA_W'(eventFlag);
                default: rdData <= '0;
            endcase
        end
    end

    a_read_snap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rdStrobe && addr == `DPCD_OFS_SNAP1 |=> rdData == `DPCD_DATA_W'($past(snapValue[0])))
        else $error("snapshot read returned the wrong value");
    a_fetch_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rdStrobe && addr == `DPCD_OFS_FETCH2 |=> rdData == `DPCD_DATA_W'(snapValue[1]))
        else $error("fetch read and snapshot disagree");
    a_gate_persist: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(wrStrobe && addr == `DPCD_OFS_GATE) |=> $stable(gate))
        else $error("gate changed without a write");
    a_gate_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrStrobe && addr == `DPCD_OFS_GATE |=> gate == $past(wrData[NCNT-1:0]))
        else $error("gate write did not set both counters");
    a_trig_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(pinLevel[`DPCD_TRIG_BIT]) |=> eventStart ##1 !eventStart)
        else $error("trigger edge did not give a single start pulse");
    a_out_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrStrobe && addr == `DPCD_OFS_OUT_HIGH && wrData[2:0] == 3'h5 |=> digOut[5])
        else $error("output set did not drive the line high");
    a_cmd_self: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrStrobe && addr == `DPCD_OFS_CLEAR |=> !cntBus[0].clear || (wrStrobe && addr == `DPCD_OFS_CLEAR))
        else $error("clear command did not return inactive");
    a_edge_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pinRise[`DPCD_CNT_IN_LSB] |=> !pinRise[`DPCD_CNT_IN_LSB])
        else $error("one input edge gave two count pulses");

    // read answers, one cycle after the strobe
    a_read_snap2: assert property (
        rdSel == dpcd_pkg::REG_SNAP2 |=> rdData == `DPCD_DATA_W'($past(snapValue[1])))
        else $error("snapshot two read wrong");
    a_fetch_first: assert property (
        rdSel == dpcd_pkg::REG_FETCH1 |=> rdData == `DPCD_DATA_W'(snapValue[0]))
        else $error("fetch one and snapshot disagree");
    a_fetch_copy1: assert property (
        rdSel == dpcd_pkg::REG_FETCH1 |=> snapValue[0] == $past(liveCount[0]))
        else $error("fetch one did not copy the count");
    a_fetch_copy2: assert property (
        rdSel == dpcd_pkg::REG_FETCH2 |=> snapValue[1] == $past(liveCount[1]))
        else $error("fetch two did not copy the count");
    a_read_gate: assert property (
        rdSel == dpcd_pkg::REG_GATE |=> rdData == `DPCD_DATA_W'($past(gate)))
        else $error("gate read wrong");
    a_read_inputs: assert property (
        rdSel == dpcd_pkg::REG_IN_ALL |=> rdData == `DPCD_DATA_W'($past(pinLevel[DIO_W-1:0])))
        else $error("input word read wrong");
    a_read_bit: assert property (
        rdStrobe && addr == `DPCD_OFS_IN_BIT5 |=> rdData == `DPCD_DATA_W'($past(pinLevel[5])))
        else $error("single input read wrong");
    a_read_outs: assert property (
        rdSel == dpcd_pkg::REG_OUT_ALL |=> rdData == `DPCD_DATA_W'($past(digOut)))
        else $error("output word read wrong");
    a_read_event: assert property (
        rdSel == dpcd_pkg::REG_EVENT |=> rdData == `DPCD_DATA_W'($past(eventFlag)))
        else $error("event flag read wrong");
    a_read_cmd: assert property (
        rdSel == dpcd_pkg::REG_CLEAR || rdSel == dpcd_pkg::REG_LATCH |=> rdData == '0)
        else $error("command register read not zero");
    a_read_idle: assert property (
        rdSel == dpcd_pkg::REG_NONE |=> rdData == '0)
        else $error("read data not zero outside a read");

    // counter commands
    a_clear_one: assert property (
        wrSel == dpcd_pkg::REG_CLEAR && wrData[0] |=> liveCount[0] == '0)
        else $error("clear did not zero counter one");
    a_clear_two: assert property (
        wrSel == dpcd_pkg::REG_CLEAR && wrData[1] |=> liveCount[1] == '0)
        else $error("clear did not zero counter two");
    a_clear_keep1: assert property (
        wrSel == dpcd_pkg::REG_CLEAR && !wrData[0] && !gate[0] |=> $stable(liveCount[0]))
        else $error("clear bit zero changed counter one");
    a_clear_keep2: assert property (
        wrSel == dpcd_pkg::REG_CLEAR && !wrData[1] && !gate[1] |=> $stable(liveCount[1]))
        else $error("clear bit zero changed counter two");
    a_latch_one: assert property (
        wrSel == dpcd_pkg::REG_LATCH && wrData[0] |=> snapValue[0] == $past(liveCount[0]))
        else $error("latch did not copy counter one");
    a_latch_two: assert property (
        wrSel == dpcd_pkg::REG_LATCH && wrData[1] |=> snapValue[1] == $past(liveCount[1]))
        else $error("latch did not copy counter two");
    a_latch_none: assert property (
        wrSel == dpcd_pkg::REG_LATCH && wrData[1:0] == 2'h0 |=> $stable(snapValue[0]) && $stable(snapValue[1]))
        else $error("empty latch command changed a snapshot");
    a_snap_quiet: assert property (
        rdSel != dpcd_pkg::REG_FETCH1 && !(wrLatch && wrData[0]) |=> $stable(snapValue[0]))
        else $error("snapshot one changed without a command");
    a_stop_two: assert property (
        !gate[1] && !cntBus[1].clear |=> $stable(liveCount[1]))
        else $error("stopped counter two changed");
    a_count_two: assert property (
        gate[1] && pinRise[`DPCD_CNT_IN_LSB + 1] && !cntBus[1].clear |=> liveCount[1] == CNT_W'($past(liveCount[1]) + CNT_W'(1)))
        else $error("counter two did not step by one");
    a_wrap_quiet: assert property (
        gate[0] && pinRise[`DPCD_CNT_IN_LSB] && !cntBus[0].clear && liveCount[0] == '1 |=> liveCount[0] == '0)
        else $error("counter one did not wrap to zero");
    a_cnt_apart: assert property (
        pinRise[`DPCD_CNT_IN_LSB] && !pinRise[`DPCD_CNT_IN_LSB + 1] && !cntBus[1].clear |=> $stable(liveCount[1]))
        else $error("counter two moved on an edge of counter one");

    // output port
    a_out_word: assert property (
        wrSel == dpcd_pkg::REG_OUT_ALL |=> digOut == $past(wrData[DIO_W-1:0]))
        else $error("output word write wrong");
    a_out_clear: assert property (
        wrSel == dpcd_pkg::REG_OUT_LOW && wrData[2:0] == 3'h0 |=> !digOut[0])
        else $error("output clear did not drive the line low");
    a_out_range: assert property (
        (wrSel == dpcd_pkg::REG_OUT_HIGH || wrSel == dpcd_pkg::REG_OUT_LOW)
            && wrData[2:1] == 2'h3 |=> $stable(digOut))
        else $error("out of range index changed an output");
    a_out_hold: assert property (
        wrSel != dpcd_pkg::REG_OUT_ALL && wrSel != dpcd_pkg::REG_OUT_HIGH
            && wrSel != dpcd_pkg::REG_OUT_LOW |=> $stable(digOut))
        else $error("outputs changed without a write");
    a_out_others: assert property (
        wrSel == dpcd_pkg::REG_OUT_HIGH && wrData[2:0] == 3'h5 |=> digOut[4:0] == $past(digOut[4:0]))
        else $error("single set touched other outputs");

    // trigger event
    a_flag_set: assert property (
        pinRise[`DPCD_TRIG_BIT] |=> eventFlag)
        else $error("trigger edge did not set the flag");
    a_flag_clear: assert property (
        wrSel == dpcd_pkg::REG_EVENT && wrData[0] && !pinRise[`DPCD_TRIG_BIT] |=> !eventFlag)
        else $error("flag clear did not take");
    a_flag_hold: assert property (
        wrSel != dpcd_pkg::REG_EVENT && !pinRise[`DPCD_TRIG_BIT] |=> $stable(eventFlag))
        else $error("flag changed without cause");
    a_start_cause: assert property (
        eventStart |-> $past(pinRise[`DPCD_TRIG_BIT]))
        else $error("start pulse without a trigger edge");
    a_edge_trig: assert property (
        pinRise[`DPCD_TRIG_BIT] |=> !pinRise[`DPCD_TRIG_BIT])
        else $error("one trigger edge gave two pulses");
endmodule // dpcd_top
`default_nettype wire

// File: tb/dpcd_pulse_src.sv
// behavioural pulse source and trigger driver on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module dpcd_pulse_src (
    // count pins and trigger pin
    output logic [1:0] cntPin,
    output logic trig
);
    // count lines rest low on their pull-downs; the trigger line rests high on its pull-up
    initial begin
        cntPin = 2'h0;
        trig = 1'b1;
    end

    // link clock of 160 ns, only present during a burst; offset keeps it off the bench clock phase
    task automatic pulses(input int ch, input int n);
        #3;
        repeat (n) begin
            cntPin[ch] = 1'b1;
            #80;
            cntPin[ch] = 1'b0;
            #80;
        end
    endtask

    task automatic level(input int ch, input logic v);
        cntPin[ch] = v;
    endtask

    task automatic trigger();
        #7;
        trig = 1'b0;
        #80;
        trig = 1'b1;
    endtask
endmodule // dpcd_pulse_src
`default_nettype wire

// File: tb/dpcd_top_tb.sv
// self-checking bench for the pulse counters and digital port
`timescale 1ns/1ps
`default_nettype none
`include "dpcd_params.svh"
module dpcd_top_tb;
    logic sys_clk;
    logic rst_n;
    logic [`DPCD_ADDR_W-1:0] addr;
    logic [`DPCD_DATA_W-1:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [`DPCD_DATA_W-1:0] rdData;
    logic [3:0] digLow;
    logic [1:0] cntPin;
    logic trig;
    logic [5:0] digOut;
    logic eventStart;
    logic eventFlag;
    logic rdSeen;
    logic [31:0] expQ[$];
    logic [31:0] rng;
    logic [31:0] v;
    int fail_count;
    int num_checks;
    int cycles;
    int evCount;

    dpcd_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .read_single_input({cntPin, digLow}), .trigIn(trig), .digOut(digOut),
        .eventStart(eventStart), .eventFlag(eventFlag));
    dpcd_pulse_src src (.cntPin(cntPin), .trig(trig));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [`DPCD_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
    endtask

    // the expected word is queued; the monitor compares it with the answer one cycle on
    task automatic rd(input logic [`DPCD_ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        expQ.push_back(e);
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
    endtask

    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        rdSeen <= rdStrobe;
        cycles++;
        if (eventStart === 1'b1) evCount++;
        if (rdSeen === 1'b1) begin
            if (expQ.size() == 0) check(rdData, 32'hffffffff);
            else check(rdData, expQ.pop_front());
        end
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        rst_n = 1'b0;
        addr = '0;
        wrData = '0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        digLow = 4'h0;
        rdSeen = 1'b0;
        rng = 32'd64787;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        evCount = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`DPCD_OFS_GATE, 32'h0);
        rd(`DPCD_OFS_SNAP1, 32'h0);
        rd(`DPCD_OFS_OUT_ALL, 32'h0);
        rd(`DPCD_OFS_EVENT, 32'h0);
        // stop, clear, then start, the order software must keep
        wr(`DPCD_OFS_GATE, 32'h0);
        wr(`DPCD_OFS_CLEAR, 32'h3);
        wr(`DPCD_OFS_GATE, 32'h3);
        fork
            src.pulses(0, 5);
            src.pulses(1, 3);
        join
        settle();
        rd(`DPCD_OFS_FETCH1, 32'h5);
        rd(`DPCD_OFS_FETCH2, 32'h3);
        rd(`DPCD_OFS_SNAP1, 32'h5);
        src.pulses(0, 2);
        settle();
        rd(`DPCD_OFS_SNAP1, 32'h5);
        wr(`DPCD_OFS_LATCH, 32'h1);
        rd(`DPCD_OFS_SNAP1, 32'h7);
        rd(`DPCD_OFS_SNAP2, 32'h3);
        wr(`DPCD_OFS_LATCH, 32'h0);
        wr(`DPCD_OFS_GATE, 32'h2);
        rd(`DPCD_OFS_GATE, 32'h2);
        fork
            src.pulses(0, 4);
            src.pulses(1, 4);
        join
        settle();
        rd(`DPCD_OFS_SNAP2, 32'h3);
        rd(`DPCD_OFS_FETCH1, 32'h7);
        rd(`DPCD_OFS_FETCH2, 32'h7);
        rd(`DPCD_OFS_LATCH, 32'h0);
        rd(`DPCD_OFS_CLEAR, 32'h0);
        wr(`DPCD_OFS_CLEAR, 32'h1);
        rd(`DPCD_OFS_FETCH1, 32'h0);
        rd(`DPCD_OFS_FETCH2, 32'h7);
        rd(`DPCD_OFS_GATE, 32'h2);
        // random outputs and inputs; pin 5 keeps counting while it is read as an input
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            wr(`DPCD_OFS_OUT_ALL, {26'h0, rng[5:0]});
            rd(`DPCD_OFS_OUT_ALL, {26'h0, rng[5:0]});
            check({26'h0, digOut}, {26'h0, rng[5:0]});
            digLow <= rng[9:6];
            src.level(1, rng[10]);
            settle();
            v = {26'h0, rng[10], 1'b0, rng[9:6]};
            rd(`DPCD_OFS_IN_ALL, v);
            for (int n = 0; n < 6; n++) begin
                rd(`DPCD_OFS_IN_BIT0 + 12'(4 * n), {31'h0, v[n]});
            end
        end
        wr(`DPCD_OFS_OUT_ALL, 32'h0);
        wr(`DPCD_OFS_OUT_HIGH, 32'h5);
        wr(`DPCD_OFS_OUT_HIGH, 32'h1);
        wr(`DPCD_OFS_OUT_HIGH, 32'h6);
        wr(`DPCD_OFS_OUT_LOW, 32'h1);
        @(posedge sys_clk);
        check({26'h0, digOut}, 32'h20);
        src.trigger();
        settle();
        check(evCount, 32'h1);
        check({31'h0, eventFlag}, 32'h1);
        rd(`DPCD_OFS_EVENT, 32'h1);
        wr(`DPCD_OFS_EVENT, 32'h1);
        rd(`DPCD_OFS_EVENT, 32'h0);
        rd(12'h7fc, 32'h0);
        repeat (3) @(posedge sys_clk);
        conclude();
    end
endmodule // dpcd_top_tb
`default_nettype wire
